// [spi_fifo_pkg.sv]
// Constants shared by the serial FIFO and power-table access block.
// Assumes a serial bus master with clock idle low, data sampled on rise.
package spi_fifo_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Header byte layout and addresses
  localparam int           HDR_RW_BIT       = 7;
  localparam int           HDR_BURST_BIT    = 6;
  localparam logic [5:0]   ADDR_PA_TABLE    = 6'h3e;
  localparam logic [5:0]   ADDR_FIFO        = 6'h3f;
  localparam logic [7:0]   HDR_TX_SINGLE    = 8'h3f;
  localparam logic [7:0]   HDR_TX_BURST     = 8'h7f;
  localparam logic [7:0]   HDR_RX_SINGLE    = 8'hbf;
  localparam logic [7:0]   HDR_RX_BURST     = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Status byte layout and state codes
  localparam int           STATUS_RDY_BIT   = 7;
  localparam logic [2:0]   STATE_IDLE       = 3'h0;
  localparam logic [2:0]   STATE_RX         = 3'h1;
  localparam logic [2:0]   STATE_TX         = 3'h2;
  localparam logic [2:0]   STATE_RX_OVERFLOW = 3'h6;
  localparam logic [2:0]   STATE_TX_UNDERFLOW = 3'h7;
  localparam logic [3:0]   COUNT_SAT        = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // Pin control codes, clock pin in the high bit
  localparam logic [1:0]   PIN_POWER_DOWN   = 2'h0;
  localparam logic [1:0]   PIN_TRANSMIT     = 2'h1;
  localparam logic [1:0]   PIN_IDLE         = 2'h2;
  localparam logic [1:0]   PIN_RECEIVE      = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes and reset values
  localparam int           FIFO_DEPTH       = 64;
  localparam int           PA_ENTRIES       = 8;
  localparam logic [7:0]   PA_RESET         = 8'h00;
  localparam logic [2:0]   BIT_LAST         = 3'h7;

endpackage

// [fifo_power_amp_table_spi_access.sv]
// Serial access to both FIFOs, power table, shared pin, pin control.
// Assumes mclk is the crystal clock and sclk, from the host,
// stops outside frames; radio_state and in_sleep come
// from the main state logic.
//
// What this block does
// - Address 0x3f reaches both FIFOs, by rw bit
// - Transmit FIFO write-only, receive FIFO read-only
// - Single access is header plus one byte
// - Burst access runs until chip select rises
// - Headers 3f, 7f, bf, ff decode as FIFO accesses
// - Status per written byte shows free space before
// - Flush strobes empty their FIFO
// - Flushes honoured only in idle or FIFO error states
// - Entering sleep empties both FIFOs
// - Address 0x3e reaches the power table
// - Eight table entries, accessed from index zero
// - Index increments, wraps at seven, clears on deselect
// - Burst and rw bits steer table accesses
// - Sleep keeps only table entry zero
// - Shared pin is serial out while selected
// - Status pin a feeds serial transmit data
// - Pin control samples pins at chip select fall
// - Pin codes map to power-down, transmit, idle, receive
// - Pin control only strobes real state changes
// - Pin strobes immediate, power-down waits for deselect
// - Selecting wakes sleep into idle
// - Status count saturates at fifteen
// - Status reports overflow 110 and underflow 111
`timescale 1ns/1ps

module fifo_power_amp_table_spi_access #(
  parameter int DEPTH = spi_fifo_pkg::FIFO_DEPTH
) (
  // Core clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Serial link from the host
  input  wire logic       sclk,
  input  wire logic       chip_select_low,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            serial_out_oe,
  // Shared pin generic use
  input  wire logic       shared_generic_en,
  input  wire logic       shared_generic_value,
  // Serial transmit data pin
  input  wire logic       status_pin_a,
  input  wire logic       serial_mode_en,
  output logic            serial_tx_data,
  // Radio state and commands
  input  wire logic [2:0] radio_state,
  input  wire logic       in_sleep,
  input  wire logic       flush_tx_strobe,
  input  wire logic       flush_rx_strobe,
  input  wire logic       pin_ctrl_en,
  output logic            power_down_strobe,
  output logic            transmit_strobe,
  output logic            go_idle_strobe,
  output logic            receive_strobe,
  // Transmit FIFO drain side
  input  wire logic       tx_rd_en,
  output logic [7:0]      tx_rd_data,
  output logic            tx_empty,
  // Receive FIFO fill side
  input  wire logic       rx_wr_en,
  input  wire logic [7:0] rx_wr_data,
  output logic            rx_full,
  // Power amplifier setting
  input  wire logic [2:0] amp_power_select,
  output logic [7:0]      pa_setting
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  function automatic logic [3:0] sat4(input logic [CW-1:0] n);
    sat4 = (n > CW'(15)) ? spi_fifo_pkg::COUNT_SAT : n[3:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link side, rising edge: header and data capture
  logic [2:0]  bit_cnt_reg;
  logic [6:0]  shift_reg;
  logic        hdr_valid_reg;
  logic [7:0]  hdr_reg;
  logic        rw_first_reg;
  logic [2:0]  pa_idx_reg;
  logic        ev_tgl_reg;
  logic [7:0]  ev_data_reg;
  logic        ev_pa_reg;
  logic [2:0]  ev_idx_reg;

  wire  [7:0]  byte_in    = {shift_reg, serial_in};
  wire         byte_end   = (bit_cnt_reg == spi_fifo_pkg::BIT_LAST);
  wire         hdr_is_pa  = (hdr_reg[5:0] == spi_fifo_pkg::ADDR_PA_TABLE);
  wire         hdr_tx_wr  = (hdr_reg == spi_fifo_pkg::HDR_TX_SINGLE) ||
                            (hdr_reg == spi_fifo_pkg::HDR_TX_BURST);
  wire         hdr_rx_rd  = (hdr_reg == spi_fifo_pkg::HDR_RX_SINGLE) ||
                            (hdr_reg == spi_fifo_pkg::HDR_RX_BURST);
  wire         hdr_read   = hdr_reg[spi_fifo_pkg::HDR_RW_BIT];
  wire         hdr_burst  = hdr_reg[spi_fifo_pkg::HDR_BURST_BIT];
  wire         data_wr    = hdr_valid_reg && byte_end &&
                            (hdr_tx_wr || (hdr_is_pa && !hdr_read));

  // Deselect clears frame state so a frame opens on a header
  always_ff @(posedge sclk or posedge chip_select_low) begin
    if (chip_select_low) begin
      bit_cnt_reg   <= 3'h0;
      shift_reg     <= 7'h00;
      hdr_valid_reg <= 1'b0;
      hdr_reg       <= 8'h00;
      rw_first_reg  <= 1'b0;
      pa_idx_reg    <= 3'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg   <= byte_in[6:0];
      if (!hdr_valid_reg && bit_cnt_reg == 3'h0) begin
        rw_first_reg <= serial_in;
      end
      if (byte_end && !hdr_valid_reg) begin
        hdr_reg       <= byte_in;
        hdr_valid_reg <= 1'b1;
      end else if (byte_end) begin
        hdr_valid_reg <= hdr_burst;
        if (hdr_is_pa) begin
          pa_idx_reg <= pa_idx_reg + 3'h1;
        end
      end
    end
  end

  // Written bytes cross as a toggle; data holds a byte time
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      ev_tgl_reg  <= 1'b0;
      ev_data_reg <= 8'h00;
      ev_pa_reg   <= 1'b0;
      ev_idx_reg  <= 3'h0;
    end else if (data_wr) begin
      ev_tgl_reg  <= ~ev_tgl_reg;
      ev_data_reg <= byte_in;
      ev_pa_reg   <= hdr_is_pa;
      ev_idx_reg  <= pa_idx_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side, falling edge: serial out
  logic [2:0]  phase_reg;
  logic        out_data_reg;
  logic [7:0]  out_byte_reg;
  logic        ld_tgl_reg;
  logic [7:0]  rx_head_reg;
  logic [7:0]  pa_mem [spi_fifo_pkg::PA_ENTRIES];
  logic [2:0]  state_pub_reg;
  logic        rdy_n_pub_reg;
  logic [3:0]  tx_free_pub_reg;
  logic [3:0]  rx_avail_pub_reg;

  wire         load_slot  = (bit_cnt_reg == 3'h0) && hdr_valid_reg;
  wire         load_rx    = load_slot && hdr_rx_rd;
  wire         load_pa    = load_slot && hdr_is_pa && hdr_read;
  wire         rw_sel     = hdr_valid_reg ? hdr_read : rw_first_reg;
  wire  [7:0]  status_byte = {rdy_n_pub_reg, state_pub_reg,
                              rw_sel ? rx_avail_pub_reg : tx_free_pub_reg};
  wire  [2:0]  out_pos    = spi_fifo_pkg::BIT_LAST - phase_reg;
  wire         so_bit     = out_data_reg ? out_byte_reg[out_pos]
                                         : status_byte[out_pos];

  always_ff @(negedge sclk or posedge chip_select_low) begin
    if (chip_select_low) begin
      phase_reg    <= 3'h0;
      out_data_reg <= 1'b0;
      out_byte_reg <= 8'h00;
    end else begin
      phase_reg <= bit_cnt_reg;
      if (bit_cnt_reg == 3'h0) begin
        out_data_reg <= load_rx || load_pa;
        out_byte_reg <= load_pa ? pa_mem[pa_idx_reg] : rx_head_reg;
      end
    end
  end

  // Each receive byte sent asks the core to pop it
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      ld_tgl_reg <= 1'b0;
    end else if (load_rx) begin
      ld_tgl_reg <= ~ld_tgl_reg;
    end
  end

  // Status or read data is serial out while selected, else generic or released
  assign serial_out    = chip_select_low ? shared_generic_value : so_bit;
  assign serial_out_oe = !chip_select_low || shared_generic_en;

  ////////////////////////////////////////////////////////////////////////////
  // Core side synchronisers
  logic [1:0]  ev_sync_reg;
  logic        ev_seen_reg;
  logic [1:0]  ld_sync_reg;
  logic        ld_seen_reg;
  logic [1:0]  cs_sync_reg;
  logic        cs_prev_reg;
  logic [1:0]  si_sync_reg;
  logic [1:0]  sck_sync_reg;
  logic [1:0]  pin_prev_reg;
  logic [1:0]  pina_sync_reg;
  logic        sleep_prev_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ev_sync_reg    <= 2'h0;
      ev_seen_reg    <= 1'b0;
      ld_sync_reg    <= 2'h0;
      ld_seen_reg    <= 1'b0;
      cs_sync_reg    <= 2'h3;
      cs_prev_reg    <= 1'b1;
      si_sync_reg    <= 2'h0;
      sck_sync_reg   <= 2'h0;
      pin_prev_reg   <= 2'h0;
      pina_sync_reg  <= 2'h0;
      sleep_prev_reg <= 1'b0;
    end else begin
      ev_sync_reg    <= {ev_sync_reg[0], ev_tgl_reg};
      ev_seen_reg    <= ev_sync_reg[1];
      ld_sync_reg    <= {ld_sync_reg[0], ld_tgl_reg};
      ld_seen_reg    <= ld_sync_reg[1];
      cs_sync_reg    <= {cs_sync_reg[0], chip_select_low};
      cs_prev_reg    <= cs_sync_reg[1];
      si_sync_reg    <= {si_sync_reg[0], serial_in};
      sck_sync_reg   <= {sck_sync_reg[0], sclk};
      pin_prev_reg   <= {sck_sync_reg[1], si_sync_reg[1]};
      pina_sync_reg  <= {pina_sync_reg[0], status_pin_a};
      sleep_prev_reg <= in_sleep;
    end
  end

  wire         ev_pulse    = ev_sync_reg[1] ^ ev_seen_reg;
  wire         ld_pulse    = ld_sync_reg[1] ^ ld_seen_reg;
  wire         cs_fall     = cs_prev_reg && !cs_sync_reg[1];
  wire         cs_rise     = !cs_prev_reg && cs_sync_reg[1];
  wire         sleep_entry = in_sleep && !sleep_prev_reg;
  wire         flush_ok    = (radio_state == spi_fifo_pkg::STATE_IDLE) ||
                      (radio_state == spi_fifo_pkg::STATE_RX_OVERFLOW) ||
                      (radio_state == spi_fifo_pkg::STATE_TX_UNDERFLOW);
  // Refused flushes fall through with no effect at all
  wire         tx_flush    = (flush_tx_strobe && flush_ok) ||
                             sleep_entry;
  wire         rx_flush    = (flush_rx_strobe && flush_ok) ||
                             sleep_entry;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO
  logic [7:0]    tx_mem [DEPTH];
  logic [AW-1:0] tx_wr_ptr_reg;
  logic [AW-1:0] tx_rd_ptr_reg;
  logic [CW-1:0] tx_count_reg;

  wire  tx_push = ev_pulse && !ev_pa_reg && (tx_count_reg != DEPTH_C);
  wire  tx_pop  = tx_rd_en && (tx_count_reg != '0);
  assign tx_empty = (tx_count_reg == '0);

  always_ff @(posedge mclk) begin
    if (tx_push) begin
      tx_mem[tx_wr_ptr_reg] <= ev_data_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || tx_flush) begin
      tx_wr_ptr_reg <= '0;
      tx_rd_ptr_reg <= '0;
      tx_count_reg  <= '0;
      tx_rd_data    <= 8'h00;
    end else begin
      if (tx_push) begin
        tx_wr_ptr_reg <= tx_wr_ptr_reg + AW'(1);
      end
      if (tx_pop) begin
        tx_rd_ptr_reg <= tx_rd_ptr_reg + AW'(1);
        tx_rd_data    <= tx_mem[tx_rd_ptr_reg];
      end
      tx_count_reg <= tx_count_reg + CW'(tx_push) - CW'(tx_pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO
  logic [7:0]    rx_mem [DEPTH];
  logic [AW-1:0] rx_wr_ptr_reg;
  logic [AW-1:0] rx_rd_ptr_reg;
  logic [CW-1:0] rx_count_reg;

  wire  rx_push = rx_wr_en && (rx_count_reg != DEPTH_C);
  wire  rx_pop  = ld_pulse && (rx_count_reg != '0);
  assign rx_full = (rx_count_reg == DEPTH_C);

  always_ff @(posedge mclk) begin
    if (rx_push) begin
      rx_mem[rx_wr_ptr_reg] <= rx_wr_data;
    end
  end

  // Head refreshes well before the next byte slot
  always_ff @(posedge mclk) begin
    if (rst || rx_flush) begin
      rx_wr_ptr_reg <= '0;
      rx_rd_ptr_reg <= '0;
      rx_count_reg  <= '0;
      rx_head_reg   <= 8'h00;
    end else begin
      if (rx_push) begin
        rx_wr_ptr_reg <= rx_wr_ptr_reg + AW'(1);
      end
      if (rx_pop) begin
        rx_rd_ptr_reg <= rx_rd_ptr_reg + AW'(1);
      end
      rx_count_reg <= rx_count_reg + CW'(rx_push) - CW'(rx_pop);
      rx_head_reg  <= rx_mem[rx_rd_ptr_reg];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power table; link reads it only with no write in flight
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < spi_fifo_pkg::PA_ENTRIES; i++) begin
        pa_mem[i] <= spi_fifo_pkg::PA_RESET;
      end
      pa_setting <= spi_fifo_pkg::PA_RESET;
    end else begin
      if (sleep_entry) begin
        for (int i = 1; i < spi_fifo_pkg::PA_ENTRIES; i++) begin
          pa_mem[i] <= spi_fifo_pkg::PA_RESET;
        end
      end else if (ev_pulse && ev_pa_reg) begin
        pa_mem[ev_idx_reg] <= ev_data_reg;
      end
      pa_setting <= pa_mem[amp_power_select];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status for the link; free space counted before the write
  // Multi-bit fields may tear if they change mid-byte
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_pub_reg    <= spi_fifo_pkg::STATE_IDLE;
      rdy_n_pub_reg    <= 1'b1;
      tx_free_pub_reg  <= spi_fifo_pkg::COUNT_SAT;
      rx_avail_pub_reg <= 4'h0;
    end else begin
      state_pub_reg    <= radio_state;
      rdy_n_pub_reg    <= in_sleep;
      tx_free_pub_reg  <= sat4(DEPTH_C - tx_count_reg);
      rx_avail_pub_reg <= sat4(rx_count_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin control and wake; pins taken the cycle before the fall
  logic        pd_pending_reg;
  wire  [1:0]  pin_code = pin_prev_reg;
  wire         pin_go   = pin_ctrl_en && cs_fall;
  wire         want_pd  = pin_go && (pin_code == spi_fifo_pkg::PIN_POWER_DOWN)
                          && !in_sleep;
  wire         want_tx  = pin_go && (pin_code == spi_fifo_pkg::PIN_TRANSMIT)
                          && (radio_state != spi_fifo_pkg::STATE_TX);
  wire         want_idle = pin_go && (pin_code == spi_fifo_pkg::PIN_IDLE)
                          && (radio_state != spi_fifo_pkg::STATE_IDLE);
  wire         want_rx  = pin_go && (pin_code == spi_fifo_pkg::PIN_RECEIVE)
                          && (radio_state != spi_fifo_pkg::STATE_RX);

  always_ff @(posedge mclk) begin
    if (rst) begin
      pd_pending_reg    <= 1'b0;
      power_down_strobe <= 1'b0;
      transmit_strobe   <= 1'b0;
      go_idle_strobe    <= 1'b0;
      receive_strobe    <= 1'b0;
      serial_tx_data    <= 1'b0;
    end else begin
      pd_pending_reg    <= want_pd || (pd_pending_reg && !cs_rise);
      power_down_strobe <= pd_pending_reg && cs_rise;
      transmit_strobe   <= want_tx;
      go_idle_strobe    <= want_idle || (cs_fall && in_sleep);
      receive_strobe    <= want_rx;
      serial_tx_data    <= serial_mode_en &&
                           (radio_state == spi_fifo_pkg::STATE_TX) &&
                           pina_sync_reg[1];
    end
  end

endmodule

// [spi_access_props.sv]
// Checker on the ports of the serial access block.
// Assumes it is bound into the block, mclk domain only.
`timescale 1ns/1ps
module spi_access_props #(
  parameter int DEPTH = 64
) (
  // Core clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // Link and shared pin
  input wire logic       chip_select_low,
  input wire logic       serial_out,
  input wire logic       serial_out_oe,
  input wire logic       shared_generic_en,
  input wire logic       shared_generic_value,
  // State, commands and strobes
  input wire logic [2:0] radio_state,
  input wire logic       in_sleep,
  input wire logic       serial_mode_en,
  input wire logic       serial_tx_data,
  input wire logic       flush_tx_strobe,
  input wire logic       flush_rx_strobe,
  input wire logic       pin_ctrl_en,
  input wire logic       power_down_strobe,
  input wire logic       transmit_strobe,
  input wire logic       go_idle_strobe,
  input wire logic       receive_strobe,
  // FIFO sides
  input wire logic       tx_rd_en,
  input wire logic       tx_empty,
  input wire logic       rx_full
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  wire [3:0] stb = {receive_strobe, go_idle_strobe, transmit_strobe,
                    power_down_strobe};
  wire ok_flush = radio_state == spi_fifo_pkg::STATE_IDLE ||
                  radio_state == spi_fifo_pkg::STATE_RX_OVERFLOW ||
                  radio_state == spi_fifo_pkg::STATE_TX_UNDERFLOW;

  ////////////////////////////////////////////////////////////////////////////
  property p_one_strobe; $onehot0(stb); endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("strobes overlap");
  property p_strobe_pulse; |stb |=> !(|stb); endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("long strobe");
  property p_pd_deferred;
    power_down_strobe |-> chip_select_low && $past(chip_select_low, 3);
  endproperty
  a_pd_deferred: assert property (p_pd_deferred) else $error("early pd");
  property p_pin_gate;
    power_down_strobe || transmit_strobe || receive_strobe |-> pin_ctrl_en;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin strobe off");
  property p_no_restart;
    (receive_strobe -> radio_state != spi_fifo_pkg::STATE_RX) &&
    (transmit_strobe -> radio_state != spi_fifo_pkg::STATE_TX);
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("restart");
  property p_wake;
    $fell(chip_select_low) && in_sleep |-> ##[1:8] go_idle_strobe;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake strobe");
  property p_so_selected; !chip_select_low |-> serial_out_oe; endproperty
  a_so_selected: assert property (p_so_selected) else $error("so off");
  property p_so_generic;
    chip_select_low |-> serial_out_oe == shared_generic_en &&
      (!shared_generic_en || serial_out == shared_generic_value);
  endproperty
  a_so_generic: assert property (p_so_generic) else $error("pin use");
  property p_flush_tx; flush_tx_strobe && ok_flush |=> tx_empty; endproperty
  a_flush_tx: assert property (p_flush_tx) else $error("tx not flushed");
  property p_flush_rx; flush_rx_strobe && ok_flush |=> !rx_full; endproperty
  a_flush_rx: assert property (p_flush_rx) else $error("rx not flushed");
  property p_refused;
    flush_tx_strobe && !ok_flush && !tx_empty && !tx_rd_en |=> !tx_empty;
  endproperty
  a_refused: assert property (p_refused) else $error("flush not refused");
  property p_sleep; $rose(in_sleep) |=> tx_empty && !rx_full; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep kept data");
  property p_serial_tx;
    serial_tx_data |-> $past(serial_mode_en) &&
      $past(radio_state) == spi_fifo_pkg::STATE_TX;
  endproperty
  a_serial_tx: assert property (p_serial_tx) else $error("tx data gate");
endmodule

bind fifo_power_amp_table_spi_access spi_access_props #(.DEPTH(DEPTH)) u_props (.*);

// [host_model.sv]
// Host serial master model for the link pins.
// Assumes data is taken on sclk rise and shifted on fall.
`timescale 1ns/1ps
module host_model (
  // Link pins
  output logic      sclk,
  output logic      chip_select_low,
  output logic      serial_in,
  input  wire logic serial_out
);
  initial begin
    sclk = 1'b0;
    chip_select_low = 1'b1;
    serial_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Deselect between reads rewinds the table index
  task automatic sel(input logic on);
    chip_select_low = !on;
    #200;
  endtask
  // One byte MSB first; gap lets the core catch up
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      serial_in = d[i];
      #3;
      q[i] = serial_out;
      sclk = 1'b1;
      #3 sclk = 1'b0;
    end
    serial_in = ~d[0];
    #200;
  endtask
  // Pin code set while deselected, latched by the select fall
  task automatic pin_cmd(input logic [1:0] code);
    {sclk, serial_in} = code;
    #110 chip_select_low = 1'b0;
    #200 {sclk, serial_in} = 2'b00;
    chip_select_low = 1'b1;
    #400;
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the serial access block.
// Assumes host_model drives the link pins.
`timescale 1ns/1ps
module tb;
  localparam int DEPTH = 16;
  typedef struct packed {
    logic [2:0] sel;
    logic [7:0] val;
  } row_s;
  logic       mclk, sclk, chip_select_low, serial_in, serial_out;
  logic       serial_out_oe, serial_tx_data, tx_empty, rx_full;
  logic [3:0] stb;
  logic [7:0] tx_rd_data, pa_setting, q;
  logic       rst, in_sleep, pin_ctrl_en, shared_generic_en, status_pin_a;
  logic       shared_generic_value, serial_mode_en, tx_rd_en, rx_wr_en;
  logic       flush_tx_strobe, flush_rx_strobe;
  logic [2:0] radio_state, amp_power_select;
  logic [7:0] rx_wr_data;
  int         err_total = 0, n_compared = 0, cyc = 0;
  int         n_str[4] = '{0, 0, 0, 0};
  int         snap[4];
  logic [2:0] fl_st[3] = '{3'h0, 3'h6, 3'h7};
  row_s       rows[8] = '{'{3'h0, 8'ha8}, '{3'h1, 8'ha1}, '{3'h2, 8'ha2},
    '{3'h3, 8'ha3}, '{3'h4, 8'ha4}, '{3'h5, 8'ha5}, '{3'h6, 8'ha6},
    '{3'h7, 8'ha7}};

  fifo_power_amp_table_spi_access #(.DEPTH(DEPTH)) DUT (.*,
    .power_down_strobe(stb[0]), .transmit_strobe(stb[1]),
    .go_idle_strobe(stb[2]), .receive_strobe(stb[3]));
  host_model h (.sclk, .chip_select_low, .serial_in, .serial_out);

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Strobe counters and run ceiling
  always @(posedge mclk) begin
    cyc++;
    for (int i = 0; i < 4; i++)
      if (stb[i] === 1'b1) n_str[i]++;
    if (cyc == 12000) begin
      err_total++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [7:0] st_byte(input logic [2:0] s, input int n);
    return {1'b0, s, (n > 15) ? 4'hf : 4'(n)};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Flush pulse, state set a cycle before
  task automatic flush(input logic tx, input logic [2:0] st);
    tick(1);
    radio_state = st;
    tick(1);
    flush_tx_strobe = tx;
    flush_rx_strobe = !tx;
    tick(1);
    flush_tx_strobe = 1'b0;
    flush_rx_strobe = 1'b0;
    tick(2);
  endtask
  task automatic tx_one(input logic [7:0] d);
    h.sel(1'b1);
    h.xfer(8'h3f, q);
    h.xfer(d, q);
    h.sel(1'b0);
  endtask
  task automatic rx_push(input logic [7:0] d);
    tick(1);
    rx_wr_en = 1'b1;
    rx_wr_data = d;
    tick(1);
    rx_wr_en = 1'b0;
  endtask
  task automatic tx_pop(input logic [7:0] exp);
    tick(1);
    tx_rd_en = 1'b1;
    tick(1);
    tx_rd_en = 1'b0;
    tick(1);
    check("tx_rd_data", tx_rd_data, exp);
  endtask
  task automatic pa_check(input logic [2:0] s, input logic [7:0] exp);
    tick(1);
    amp_power_select = s;
    tick(2);
    check("pa_setting", pa_setting, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {in_sleep, pin_ctrl_en, shared_generic_en, shared_generic_value,
     status_pin_a, serial_mode_en, flush_tx_strobe, flush_rx_strobe,
     tx_rd_en, rx_wr_en, radio_state, amp_power_select, rx_wr_data} = '0;
    tick(10);
    rst = 1'b0;
    tick(5);
    check("reset", {2'h0, tx_empty, rx_full, stb}, 8'h20);
    pa_check(3'h5, 8'h00);
    // Burst of nine wraps the index onto entry zero
    h.sel(1'b1);
    h.xfer(8'h7e, q);
    for (int i = 0; i < 9; i++)
      h.xfer(8'ha0 + 8'(i), q);
    h.sel(1'b0);
    foreach (rows[i])
      pa_check(rows[i].sel, rows[i].val);
    h.sel(1'b1);
    h.xfer(8'hfe, q);
    for (int i = 0; i < 9; i++) begin
      h.xfer(8'h00, q);
      check("table read", q, rows[i % 8].val);
    end
    h.sel(1'b0);
    h.sel(1'b1);
    h.xfer(8'h3e, q);
    h.xfer(8'h55, q);
    h.sel(1'b0);
    h.sel(1'b1);
    h.xfer(8'hbe, q);
    h.xfer(8'h00, q);
    h.sel(1'b0);
    check("readback", q, 8'h55);
    // Overfill transmit; last byte refused
    h.sel(1'b1);
    h.xfer(8'h3f, q);
    check("status", q, st_byte(3'h0, DEPTH));
    h.xfer(8'hd0, q);
    check("status", q, st_byte(3'h0, DEPTH));
    h.xfer(8'h7f, q);
    for (int i = 1; i <= DEPTH; i++) begin
      h.xfer(8'hd0 + 8'(i), q);
      check("status", q, st_byte(3'h0, DEPTH - i));
    end
    h.sel(1'b0);
    for (int i = 0; i < DEPTH; i++)
      tx_pop(8'hd0 + 8'(i));
    check("tx_empty", {7'h0, tx_empty}, 8'h01);
    foreach (fl_st[k]) begin
      tx_one(8'h11);
      flush(1'b1, spi_fifo_pkg::STATE_RX);
      check("tx_empty", {7'h0, tx_empty}, 8'h00);
      flush(1'b1, fl_st[k]);
      check("tx_empty", {7'h0, tx_empty}, 8'h01);
    end
    // Receive side: singles then a burst, then flush
    for (int i = 0; i < DEPTH; i++)
      rx_push(8'he0 + 8'(i));
    check("rx_full", {7'h0, rx_full}, 8'h01);
    h.sel(1'b1);
    for (int i = 0; i < 3; i++) begin
      h.xfer(8'hbf, q);
      check("status", q, st_byte(3'h7, DEPTH - i));
      h.xfer(8'h00, q);
      check("rx data", q, 8'he0 + 8'(i));
    end
    h.xfer(8'hff, q);
    for (int i = 3; i < 6; i++) begin
      h.xfer(8'h00, q);
      check("rx data", q, 8'he0 + 8'(i));
    end
    h.sel(1'b0);
    flush(1'b0, spi_fifo_pkg::STATE_RX_OVERFLOW);
    h.sel(1'b1);
    h.xfer(8'hbf, q);
    h.sel(1'b0);
    check("status", q, st_byte(3'h6, 0));
    // Pin control; current state code gives no strobe
    radio_state = spi_fifo_pkg::STATE_IDLE;
    pin_ctrl_en = 1'b1;
    for (int c = 0; c < 4; c++) begin
      snap = n_str;
      h.pin_cmd(2'(c));
      for (int j = 0; j < 4; j++)
        check("strobes", 8'(n_str[j] - snap[j]), 8'(j == c && c != 2));
    end
    tick(1);
    pin_ctrl_en = 1'b0;
    snap = n_str;
    h.pin_cmd(2'h3);
    check("strobe off", 8'(n_str[3] - snap[3]), 8'h00);
    // Serial tx data, shared pin deselected
    tick(1);
    serial_mode_en = 1'b1;
    status_pin_a = 1'b1;
    radio_state = spi_fifo_pkg::STATE_TX;
    tick(5);
    check("serial_tx_data", {7'h0, serial_tx_data}, 8'h01);
    radio_state = spi_fifo_pkg::STATE_IDLE;
    shared_generic_en = 1'b1;
    shared_generic_value = 1'b1;
    tick(5);
    check("pins", {5'h0, serial_tx_data, serial_out_oe, serial_out}, 8'h03);
    shared_generic_en = 1'b0;
    tick(1);
    check("oe", {7'h0, serial_out_oe}, 8'h00);
    // Sleep flushes, keeps entry zero; select wakes
    tx_one(8'h22);
    rx_push(8'h33);
    in_sleep = 1'b1;
    tick(3);
    check("sleep", {6'h0, tx_empty, rx_full}, 8'h02);
    foreach (rows[i])
      pa_check(rows[i].sel, (i == 0) ? 8'h55 : 8'h00);
    snap = n_str;
    h.sel(1'b1);
    h.xfer(8'hbf, q);
    h.sel(1'b0);
    check("status", q, 8'h80);
    check("wake", 8'(n_str[2] - snap[2]), 8'h01);
    end_sim();
  end
endmodule
